/* common/tcm_map.svh */
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define TCM_ADDR_W          8
`define TCM_MODE_CFG_OFS    8'h1c
`define TCM_CHAN_EN_OFS     8'h20
`define TCM_STATUS_OFS      8'h40
`define TCM_MODE_CFG_RST    16'h0000
`define TCM_CHAN_EN_RST     16'h0000
`define TCM_MODE_CFG_MASK   16'hffff
`define TCM_CHAN_EN_MASK    16'h3300

// ****************************************
// Field positions, per channel
// ****************************************
`define TCM_CH_STRIDE       8
`define TCM_DIR_LSB         0
`define TCM_PSC_LSB         2
`define TCM_FAST_BIT        2
`define TCM_BUF_BIT         3
`define TCM_FILT_LSB        4
`define TCM_MODE_LSB        4
`define TCM_EN_BASE         8
`define TCM_EN_STRIDE       4
`define TCM_POL_OFS         1
`define TCM_STAT_LVL_LSB    0
`define TCM_STAT_CNT_LSB    8

// ****************************************
// Sampling
// ****************************************
`define TCM_DIV_W           5

`endif

/* common/tcm_pkg.sv */
package tcm_pkg;

    typedef enum logic [1:0] {
        TCM_DIR_OUTPUT = 2'b00,
        TCM_DIR_OWN    = 2'b01,
        TCM_DIR_PAIR   = 2'b10,
        TCM_DIR_TRIG   = 2'b11
    } tcm_dir_e;

    typedef enum logic [2:0] {
        TCM_RATE_1  = 3'b000,
        TCM_RATE_2  = 3'b001,
        TCM_RATE_4  = 3'b010,
        TCM_RATE_8  = 3'b011,
        TCM_RATE_16 = 3'b100,
        TCM_RATE_32 = 3'b101
    } tcm_rate_e;

    typedef struct packed {
        logic [3:0] filter;
        logic [1:0] prescale;
        tcm_dir_e   dir;
    } tcm_in_cfg_s;

    typedef struct packed {
        logic       is_output;
        logic [2:0] mode;
        logic       buf_en;
        logic       fast_en;
    } tcm_out_cfg_s;

endpackage

/* logic/tcm_capture_chan.sv */
`timescale 1ns/100ps
module tcm_capture_chan (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Configuration
    input  tcm_pkg::tcm_in_cfg_s      cfg,
    input  wire logic                 chan_en,
    input  wire logic                 polarity,
    input  wire logic [4:0]           tick,
    // Sources, already synchronised
    input  wire logic                 own_in,
    input  wire logic                 pair_in,
    input  wire logic                 trig_in,
    // Results
    output logic                      filt_level,
    output logic                      capture_pulse
);
    logic                is_input;
    logic                src;
    tcm_pkg::tcm_rate_e  rate;
    logic [2:0]          need_m1;
    logic                sample_en;
    logic [2:0]          fcnt_reg;
    logic                filt_reg;
    logic                prev_lvl_reg;
    logic                lvl;
    logic                edge_det;
    logic [2:0]          psc_mask;
    logic [2:0]          psc_cnt_reg;
    logic                fire;
    logic                cap_reg;

    assign is_input = (cfg.dir != tcm_pkg::TCM_DIR_OUTPUT);

    always_comb begin
        case (cfg.dir)
            tcm_pkg::TCM_DIR_OWN:  src = own_in;
            tcm_pkg::TCM_DIR_PAIR: src = pair_in;
            tcm_pkg::TCM_DIR_TRIG: src = trig_in;
            default:               src = 1'b0;
        endcase
    end

    // ****************************************
    // Filter code decode
    // ****************************************
    always_comb begin
        case (cfg.filter)
            4'h0: begin rate = tcm_pkg::TCM_RATE_1;  need_m1 = 3'd0; end
            4'h1: begin rate = tcm_pkg::TCM_RATE_1;  need_m1 = 3'd1; end
            4'h2: begin rate = tcm_pkg::TCM_RATE_1;  need_m1 = 3'd3; end
            4'h3: begin rate = tcm_pkg::TCM_RATE_1;  need_m1 = 3'd7; end
            4'h4: begin rate = tcm_pkg::TCM_RATE_2;  need_m1 = 3'd5; end
            4'h5: begin rate = tcm_pkg::TCM_RATE_2;  need_m1 = 3'd7; end
            4'h6: begin rate = tcm_pkg::TCM_RATE_4;  need_m1 = 3'd5; end
            4'h7: begin rate = tcm_pkg::TCM_RATE_4;  need_m1 = 3'd7; end
            4'h8: begin rate = tcm_pkg::TCM_RATE_8;  need_m1 = 3'd5; end
            4'h9: begin rate = tcm_pkg::TCM_RATE_8;  need_m1 = 3'd7; end
            4'ha: begin rate = tcm_pkg::TCM_RATE_16; need_m1 = 3'd4; end
            4'hb: begin rate = tcm_pkg::TCM_RATE_16; need_m1 = 3'd5; end
            4'hc: begin rate = tcm_pkg::TCM_RATE_16; need_m1 = 3'd7; end
            4'hd: begin rate = tcm_pkg::TCM_RATE_32; need_m1 = 3'd4; end
            4'he: begin rate = tcm_pkg::TCM_RATE_32; need_m1 = 3'd5; end
            default: begin rate = tcm_pkg::TCM_RATE_32; need_m1 = 3'd7; end
        endcase
    end

    assign sample_en = (rate == tcm_pkg::TCM_RATE_1) ? 1'b1 : tick[3'(rate - 3'd1)];

    // Count differing samples; any agreeing sample restarts the run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fcnt_reg <= 3'd0;
            filt_reg <= 1'b0;
        end else if (!is_input) begin
            fcnt_reg <= 3'd0;
            filt_reg <= 1'b0;
        end else if (sample_en) begin
            if (src == filt_reg) begin
                fcnt_reg <= 3'd0;
            end else if (fcnt_reg == need_m1) begin
                filt_reg <= src;
                fcnt_reg <= 3'd0;
            end else begin
                fcnt_reg <= fcnt_reg + 3'd1;
            end
        end
    end

    assign lvl      = filt_reg ^ polarity;
    // Old level seen through today's polarity: a polarity write alone is no edge
    assign edge_det = lvl & ~(prev_lvl_reg ^ polarity);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_lvl_reg <= 1'b0;
        end else begin
            prev_lvl_reg <= filt_reg;
        end
    end

    always_comb begin
        case (cfg.prescale)
            2'b00:   psc_mask = 3'd0;
            2'b01:   psc_mask = 3'd1;
            2'b10:   psc_mask = 3'd3;
            default: psc_mask = 3'd7;
        endcase
    end

    assign fire = edge_det && is_input && chan_en && (psc_cnt_reg == psc_mask);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            psc_cnt_reg <= 3'd0;
            cap_reg     <= 1'b0;
        end else begin
            cap_reg <= fire;
            if (!is_input || !chan_en) begin
                psc_cnt_reg <= 3'd0;
            end else if (edge_det) begin
                psc_cnt_reg <= fire ? 3'd0 : psc_cnt_reg + 3'd1;
            end
        end
    end

    assign filt_level    = filt_reg;
    assign capture_pulse = cap_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_filter_run_length:
    assert property (($changed(filt_reg) && $past(is_input) && is_input && $stable(cfg))
        |-> ($past(sample_en) && $past(fcnt_reg) == $past(need_m1)))
        else $error("filter output changed without a full run of samples");
    a_half_rate_sample:
    assert property ((is_input && cfg.filter == 4'h4 && $stable(cfg) && $changed(filt_reg))
        |-> $past(tick[0]))
        else $error("code 4 filter changed off the half-rate tick");
    a_sixteenth_rate:
    assert property ((is_input && cfg.filter inside {4'ha, 4'hb, 4'hc} && $stable(cfg)
        && $changed(filt_reg)) |-> $past(tick[3]))
        else $error("sixteenth-rate filter changed off its tick");
    a_prescale_count:
    assert property (capture_pulse |-> $past(psc_cnt_reg) == $past(psc_mask))
        else $error("capture fired before prescaler count reached");
    a_input_only_capture:
    assert property ((!is_input || !chan_en) |=> !capture_pulse)
        else $error("capture while channel is output or disabled");
    a_polarity_edge:
    assert property (capture_pulse |-> ($past(filt_reg) != $past(filt_reg, 2))
        && ($past(filt_reg) != $past(polarity)))
        else $error("capture not on the selected edge");

    c_trig_capture: cover property (cfg.dir == tcm_pkg::TCM_DIR_TRIG && capture_pulse);
    c_prescale_eight: cover property (cfg.prescale == 2'b11 && capture_pulse);
    c_slow_filter: cover property (cfg.filter == 4'hf && $changed(filt_reg));

endmodule // tcm_capture_chan

/* logic/tcm_top.sv */
`timescale 1ns/100ps
`include "tcm_map.svh"
module tcm_top (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // Register port
    input  wire logic [`TCM_ADDR_W-1:0]     addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [31:0]                rdata,
    // Channel sources
    input  wire logic                       timer_input_three,
    input  wire logic                       timer_input_four,
    input  wire logic                       internal_trigger_input,
    // Capture results
    output logic      [1:0]                 capture_event,
    output logic      [1:0]                 filtered_level,
    // Compare configuration towards output stage
    output tcm_pkg::tcm_out_cfg_s           ch3_out_cfg,
    output tcm_pkg::tcm_out_cfg_s           ch4_out_cfg
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [15:0]                 mode_cfg_reg;
    logic [15:0]                 mode_cfg_next;
    logic [15:0]                 chan_en_reg;
    logic [31:0]                 rdata_reg;
    logic [31:0]                 status_word;
    logic [1:0]                  ti_meta_reg;
    logic [1:0]                  ti_sync_reg;
    logic [`TCM_DIV_W-1:0]       div_cnt_reg;
    logic [4:0]                  tick;
    logic [1:0]                  ch_en;
    logic [1:0]                  ch_pol;
    logic [1:0]                  cap_pulse;
    logic [1:0]                  filt_lvl;
    logic [7:0]                  cap_cnt_reg [2];
    tcm_pkg::tcm_in_cfg_s        in_cfg [2];
    tcm_pkg::tcm_out_cfg_s       out_cfg_reg [2];
    tcm_pkg::tcm_out_cfg_s       out_cfg_next [2];
    logic                        wr_mode;
    logic                        wr_enreg;

    assign wr_mode  = wr_en && (addr == `TCM_MODE_CFG_OFS);
    assign wr_enreg = wr_en && (addr == `TCM_CHAN_EN_OFS);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Index 0 is the third input, index 1 the fourth
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ti_meta_reg <= 2'b00;
            ti_sync_reg <= 2'b00;
        end else begin
            ti_meta_reg <= {timer_input_four, timer_input_three};
            ti_sync_reg <= ti_meta_reg;
        end
    end

    // ****************************************
    // Sampling divider
    // ****************************************
    // One shared free-running count; both channels see the same phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + `TCM_DIV_W'(1);
        end
    end

    generate
        for (genvar k = 0; k < 5; k++) begin : g_tick
            assign tick[k] = &div_cnt_reg[k:0];
        end
    endgenerate

    // ****************************************
    // Mode configuration register
    // ****************************************
    // Direction field keeps its value while the channel is enabled
    always_comb begin
        mode_cfg_next = mode_cfg_reg;
        if (wr_mode) begin
            mode_cfg_next = wdata[15:0] & `TCM_MODE_CFG_MASK;
            if (chan_en_reg[`TCM_EN_BASE]) begin
                mode_cfg_next[1:0] = mode_cfg_reg[1:0];
            end
            if (chan_en_reg[`TCM_EN_BASE + `TCM_EN_STRIDE]) begin
                mode_cfg_next[9:8] = mode_cfg_reg[9:8];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_cfg_reg <= `TCM_MODE_CFG_RST;
        end else begin
            mode_cfg_reg <= mode_cfg_next;
        end
    end

    // ****************************************
    // Channel enable register
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_en_reg <= `TCM_CHAN_EN_RST;
        end else if (wr_enreg) begin
            chan_en_reg <= wdata[15:0] & `TCM_CHAN_EN_MASK;
        end
    end

    // ****************************************
    // Per-channel decode and capture
    // ****************************************
    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            localparam int B = i * `TCM_CH_STRIDE;
            localparam int E = `TCM_EN_BASE + i * `TCM_EN_STRIDE;

            // Same field layout for both channels, one byte apart
            assign in_cfg[i].filter   = mode_cfg_reg[B + `TCM_FILT_LSB +: 4];
            assign in_cfg[i].prescale = mode_cfg_reg[B + `TCM_PSC_LSB +: 2];
            assign in_cfg[i].dir      =
                tcm_pkg::tcm_dir_e'(mode_cfg_reg[B + `TCM_DIR_LSB +: 2]);
            assign ch_en[i]  = chan_en_reg[E];
            assign ch_pol[i] = chan_en_reg[E + `TCM_POL_OFS];

            // Compare fields are only passed on while the channel is an output
            always_comb begin
                out_cfg_next[i] = '0;
                if (in_cfg[i].dir == tcm_pkg::TCM_DIR_OUTPUT) begin
                    out_cfg_next[i].is_output = 1'b1;
                    out_cfg_next[i].mode      = mode_cfg_reg[B + `TCM_MODE_LSB +: 3];
                    out_cfg_next[i].buf_en    = mode_cfg_reg[B + `TCM_BUF_BIT];
                    out_cfg_next[i].fast_en   = mode_cfg_reg[B + `TCM_FAST_BIT];
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    out_cfg_reg[i] <= '0;
                end else begin
                    out_cfg_reg[i] <= out_cfg_next[i];
                end
            end

            // Own input is the channel's pin, pair input the other one
            tcm_capture_chan u_chan (
                .clk           (clk),
                .rst           (rst),
                .cfg           (in_cfg[i]),
                .chan_en       (ch_en[i]),
                .polarity      (ch_pol[i]),
                .tick          (tick),
                .own_in        (ti_sync_reg[i]),
                .pair_in       (ti_sync_reg[1 - i]),
                .trig_in       (internal_trigger_input),
                .filt_level    (filt_lvl[i]),
                .capture_pulse (cap_pulse[i])
            );

            // Wrapping count lets software see that captures happen
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cap_cnt_reg[i] <= 8'h00;
                end else if (cap_pulse[i]) begin
                    cap_cnt_reg[i] <= cap_cnt_reg[i] + 8'h01;
                end
            end
        end
    endgenerate

    // ****************************************
    // Read port
    // ****************************************
    assign status_word = {8'h00, cap_cnt_reg[1], cap_cnt_reg[0], 6'h00, filt_lvl};

    // Read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr)
                `TCM_MODE_CFG_OFS: rdata_reg <= {16'h0000, mode_cfg_reg};
                `TCM_CHAN_EN_OFS:  rdata_reg <= {16'h0000, chan_en_reg};
                `TCM_STATUS_OFS:   rdata_reg <= status_word;
                default:           rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata          = rdata_reg;
    assign capture_event  = cap_pulse;
    assign filtered_level = filt_lvl;
    assign ch3_out_cfg    = out_cfg_reg[0];
    assign ch4_out_cfg    = out_cfg_reg[1];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_dir_write_lock:
    assert property ((wr_mode && chan_en_reg[`TCM_EN_BASE + `TCM_EN_STRIDE])
        |=> $stable(mode_cfg_reg[9:8]))
        else $error("channel 4 direction changed while enabled");
    a_output_gating:
    assert property ((mode_cfg_reg[1:0] != 2'b00) |=> ch3_out_cfg == '0)
        else $error("channel 3 compare fields passed while input");
    a_ch4_mode_pass:
    assert property ((mode_cfg_reg[9:8] == 2'b00)
        |=> ch4_out_cfg.mode == $past(mode_cfg_reg[14:12]) && ch4_out_cfg.is_output)
        else $error("channel 4 compare mode not passed while output");
    a_read_one_cycle:
    assert property ((rd_en && addr == `TCM_MODE_CFG_OFS)
        |=> rdata == {16'h0000, $past(mode_cfg_reg)} ##1 ($past(rd_en) || rdata == '0))
        else $error("mode register read data wrong or held");
    a_ch4_trig_route:
    assert property ((mode_cfg_reg[9:8] == 2'b11 && mode_cfg_reg[15:12] == 4'h0
        && $stable(mode_cfg_reg)) |=> filtered_level[1] == $past(internal_trigger_input))
        else $error("channel 4 trigger source not routed");
    a_ch3_pair_route:
    assert property ((mode_cfg_reg[1:0] == 2'b10 && mode_cfg_reg[7:4] == 4'h0
        && $stable(mode_cfg_reg)) |=> filtered_level[0] == $past(ti_sync_reg[1]))
        else $error("channel 3 pair source not routed");

    c_both_capture: cover property (capture_event == 2'b11);
    c_locked_write: cover property (wr_mode && chan_en_reg[`TCM_EN_BASE]);

endmodule // tcm_top

/* sim/tcm_src_model.sv */
`timescale 1ns/100ps
module tcm_src_model (
    // Clock
    input  wire logic       clk,
    // Commanded levels: [0] input three, [1] input four, [2] trigger
    input  wire logic [2:0] lvl,
    input  wire logic       trig_sel,
    // Sources towards the block
    output logic            timer_input_three,
    output logic            timer_input_four,
    output logic            internal_trigger_input
);
    initial begin
        timer_input_three      = 1'b0;
        timer_input_four       = 1'b0;
        internal_trigger_input = 1'b0;
    end
    // Pins lag the command by a cycle, like a slow outside driver
    always @(posedge clk) begin
        timer_input_three <= lvl[0];
        timer_input_four  <= lvl[1];
    end
    // No trigger source chosen means the trigger line sits inactive
    always @(posedge clk) begin
        internal_trigger_input <= trig_sel & lvl[2];
    end
endmodule // tcm_src_model

/* sim/testbench.sv */
`timescale 1ns/100ps
`include "tcm_map.svh"
module testbench;
    logic                  clk      = 1'b0;
    logic                  rst      = 1'b1;
    logic [7:0]            addr     = 8'h00;
    logic [31:0]           wdata    = 32'h0000_0000;
    logic                  wr_en    = 1'b0;
    logic                  rd_en    = 1'b0;
    logic [2:0]            lvl      = 3'h0;
    logic                  trig_sel = 1'b0;
    logic [31:0]           rdata;
    logic                  t3, t4, trg;
    logic [1:0]            capture_event, filtered_level;
    tcm_pkg::tcm_out_cfg_s ch3_out_cfg, ch4_out_cfg;
    int                    mismatches = 0, n_compared = 0, cycles = 0;
    int                    cap_cnt [2] = '{0, 0};
    int                    per [16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    int                    nn [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};

    always #10 clk = ~clk;

    tcm_src_model src_u (.clk(clk), .lvl(lvl), .trig_sel(trig_sel),
        .timer_input_three(t3), .timer_input_four(t4), .internal_trigger_input(trg));

    tcm_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .timer_input_three(t3), .timer_input_four(t4),
        .internal_trigger_input(trg), .capture_event(capture_event),
        .filtered_level(filtered_level), .ch3_out_cfg(ch3_out_cfg),
        .ch4_out_cfg(ch4_out_cfg));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Captures are counted so a test can diff before and after
    always @(posedge clk) begin
        cycles++;
        if (capture_event[0] === 1'b1) cap_cnt[0]++;
        if (capture_event[1] === 1'b1) cap_cnt[1]++;
        if (cycles == 60000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask

    // Channel turned off before its direction changes
    task automatic set_cfg(input logic [15:0] mode, input logic [3:0] ep);
        reg_wr(`TCM_CHAN_EN_OFS, 32'h0000_0000);
        reg_wr(`TCM_MODE_CFG_OFS, {16'h0000, mode});
        reg_wr(`TCM_CHAN_EN_OFS, {18'h0, ep[3:2], 2'b00, ep[1:0], 8'h00});
        wt(10);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_regs();
        logic [31:0] d;
        reg_rd(`TCM_MODE_CFG_OFS, d);
        check(d, 32'h0000_0000, "mode reset");
        reg_wr(`TCM_MODE_CFG_OFS, 32'hffff_ffff);
        reg_rd(`TCM_MODE_CFG_OFS, d);
        check(d, 32'h0000_ffff, "mode readback");
        reg_wr(`TCM_CHAN_EN_OFS, 32'hffff_ffff);
        reg_rd(`TCM_CHAN_EN_OFS, d);
        check(d, 32'h0000_3300, "enable readback");
        reg_rd(8'h10, d);
        check(d, 32'h0000_0000, "unmapped read");
        set_cfg(16'h0000, 4'h0);
        $display("test regs done");
    endtask

    task automatic test_out_cfg();
        int c3, c4;
        set_cfg(16'h5834, 4'b0101);
        check(ch4_out_cfg, {1'b1, 3'b101, 1'b1, 1'b0}, "ch4 out cfg");
        check(ch3_out_cfg, {1'b1, 3'b011, 1'b0, 1'b1}, "ch3 out cfg");
        c3 = cap_cnt[0];
        c4 = cap_cnt[1];
        lvl <= 3'b011;
        wt(12);
        check(filtered_level, 2'b00, "output filter");
        check(cap_cnt[0] + cap_cnt[1], c3 + c4, "output capture");
        lvl <= 3'b000;
        set_cfg(16'h5835, 4'b0000);
        check(ch3_out_cfg, 6'h00, "ch3 input cfg");
        $display("test out_cfg done");
    endtask

    task automatic test_sources();
        int c0, idx;
        trig_sel <= 1'b1;
        for (int ch = 0; ch < 2; ch++) begin
            for (int d = 1; d < 4; d++) begin
                idx = (d == 3) ? 2 : (((d == 1) ^ (ch == 1)) ? 0 : 1);
                set_cfg(16'(d) << (8 * ch), 4'b0001 << (2 * ch));
                c0 = cap_cnt[ch];
                lvl <= 3'b111 & ~(3'b001 << idx);
                wt(12);
                check(cap_cnt[ch], c0, "wrong source");
                lvl <= 3'b111;
                wt(12);
                check(cap_cnt[ch], c0 + 1, "own source");
                lvl <= 3'b000;
                wt(12);
            end
        end
        set_cfg(16'h0001, 4'b0000);
        c0 = cap_cnt[0];
        lvl <= 3'b001;
        wt(12);
        check(cap_cnt[0], c0, "disabled capture");
        lvl <= 3'b000;
        $display("test sources done");
    endtask

    task automatic test_filter();
        int p, n, k;
        logic hit;
        set_cfg(16'h0001, 4'b0001);
        for (int c = 0; c < 16; c++) begin
            p = per[c];
            n = nn[c];
            hit = 1'b0;
            reg_wr(`TCM_MODE_CFG_OFS, {16'h0000, 4'(c), 4'b0001});
            wt(8);
            if (n > 1) begin
                lvl <= 3'b001;
                wt((n - 1) * p);
                lvl <= 3'b000;
                repeat (n * p + 8) begin
                    @(posedge clk);
                    if (filtered_level[0] !== 1'b0) hit = 1'b1;
                end
            end
            check(hit, 1'b0, "short pulse passed");
            lvl <= 3'b001;
            k = 0;
            do begin
                @(posedge clk);
                #1 k++;
            end while (filtered_level[0] !== 1'b1 && k < n * p + 10);
            check(k >= (n - 1) * p + 3 && k <= n * p + 4, 1'b1, "filter delay");
            lvl <= 3'b000;
            wt(n * p + 8);
        end
        $display("test filter done");
    endtask

    task automatic test_prescale();
        int          c0;
        logic [31:0] d;
        for (int ch = 0; ch < 2; ch++) begin
            for (int ps = 0; ps < 4; ps++) begin
                set_cfg(16'({2'(ps), 2'b01}) << (8 * ch), 4'b0001 << (2 * ch));
                c0 = cap_cnt[ch];
                repeat (8) begin
                    lvl <= 3'b001 << ch;
                    wt(6);
                    lvl <= 3'b000;
                    wt(6);
                end
                check(cap_cnt[ch] - c0, 8 >> ps, "prescaled count");
            end
        end
        c0 = cap_cnt[1];
        set_cfg(16'h0100, 4'b1100);
        check(cap_cnt[1], c0, "polarity write");
        lvl <= 3'b010;
        wt(12);
        check(cap_cnt[1], c0, "inverted rise");
        lvl <= 3'b000;
        wt(12);
        check(cap_cnt[1], c0 + 1, "inverted fall");
        reg_rd(`TCM_STATUS_OFS, d);
        check(d, {8'h00, 8'(cap_cnt[1]), 8'(cap_cnt[0]), 8'h00}, "status word");
        // Channel 4 still enabled: its direction must survive this write
        reg_wr(`TCM_MODE_CFG_OFS, 32'h0000_f000);
        reg_rd(`TCM_MODE_CFG_OFS, d);
        check(d, 32'h0000_f100, "direction lock");
        $display("test prescale done");
    endtask

    initial begin
        wt(10);
        rst <= 1'b0;
        test_regs();
        test_out_cfg();
        test_sources();
        test_filter();
        test_prescale();
        report_and_stop();
    end
endmodule // testbench
